// ==== common/dacbp_pkg.sv ====
package dacbp_pkg;
  // Register indices
  localparam logic [6:0] REG_UNUSED_A = 7'h10;
  localparam logic [6:0] REG_UNUSED_B = 7'h11;
  localparam logic [6:0] REG_FMT_STRM = 7'h12;
  localparam logic [6:0] REG_OUT_CLK  = 7'h13;
  localparam logic [6:0] REG_RST_BYP  = 7'h14;
  localparam logic [6:0] REG_ZERO     = 7'h15;
  // Field positions
  localparam int FMT_LSB  = 4;
  localparam int STRM_BIT = 1;
  localparam int FIR_LSB  = 2;
  localparam int OPE_BIT  = 4;
  localparam int CLOCK_DIVIDE_CTL_BIT = 3;
  localparam int CLOCK_ENABLE_CTL_BIT = 2;
  localparam int ZERO_MUTE_ENABLE_BIT = 0;
  localparam int SYSTEM_RESET_BIT_BIT = 6;
  localparam int MODE_REGISTER_RESET_BIT = 5;
  localparam int BYP_BIT  = 4;
  localparam int MONO_CHANNEL_SELECT_BIT = 2;
  localparam int OS_LSB   = 0;
  // Reset values and writable masks
  localparam logic [7:0] RST_VAL  = 8'h00;
  localparam logic [7:0] MASK_18  = 8'h7e;
  localparam logic [7:0] MASK_19  = 8'h1d;
  localparam logic [7:0] MASK_20  = 8'h77;
  // Format and rate codes
  localparam logic [2:0] FMT_16 = 3'h0;
  localparam logic [2:0] FMT_20 = 3'h1;
  localparam logic [2:0] FMT_24 = 3'h2;
  localparam logic [1:0] OS_X8  = 2'h0;
  localparam logic [1:0] OS_X16 = 2'h2;
  localparam logic [1:0] OS_X4  = 2'h3;
  // Zero detection length in samples
  localparam int ZERO_SAMPLES = 1024;
  localparam int ZCNT_W       = 11;
  // Control word layout
  localparam int CW_RW_BIT = 15;

  typedef enum logic [1:0] {
    DACBP_NORMAL = 2'b00,
    DACBP_EXTF   = 2'b01,
    DACBP_STREAM = 2'b11
  } dacbp_mode_t;

  // Link samples handed across domains
  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } dacbp_pair_t;

  // Control word on the command port
  typedef struct packed {
    logic       rd;
    logic [6:0] index;
    logic [7:0] data;
  } dacbp_cw_t;
endpackage

// ==== tb/dacbp_chk.sv ====
`timescale 1ns/1ps
// Watches mode decode, read answers and zero pins
module dacbp_chk (
  // Control clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Command port
  input wire logic        cw_valid,
  input wire logic [15:0] cw_word,
  input wire logic        rd_valid,
  // Decoded state
  input wire logic [1:0]  mode,
  input wire logic        filter_bypass,
  input wire logic        left_zero_pin,
  input wire logic        right_zero_pin,
  input wire logic [2:0]  input_format_sel,
  input wire logic [1:0]  modulator_rate_sel,
  input wire logic [1:0]  fir_response_sel,
  input wire logic [4:0]  osr_total,
  input wire logic        fir_half_rate
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Write to the reset, bypass and rate register
  wire wr20 = cw_valid && !cw_word[15] && cw_word[14:8] == 7'h14;

  a_bypass_write: assert property (
    wr20 && !$past(wr20 && cw_word[5])
      |=> filter_bypass == $past(cw_word[4]))
    else $error("bypass bit not taken from write");
  a_mode_bypass: assert property (
    mode != 2'b00 |-> filter_bypass)
    else $error("bypass mode without bypass bit");
  a_mode_register_reset_clears: assert property (
    wr20 && cw_word[5] |-> ##2 mode == 2'b00 && !filter_bypass)
    else $error("mode reset left registers set");
  a_fmt_stream: assert property (
    mode == 2'b11 |-> input_format_sel == 3'h0)
    else $error("format active in stream mode");
  a_fir_idle: assert property (
    mode != 2'b11 |-> fir_response_sel == 2'b00)
    else $error("response select outside stream mode");
  a_osr_ext: assert property (
    mode == 2'b01 |-> osr_total == (modulator_rate_sel == 2'h2 ? 5'h10 :
      modulator_rate_sel == 2'h3 ? 5'h04 : 5'h08))
    else $error("modulator multiple wrong");
  a_half_rate: assert property (
    fir_half_rate == (mode == 2'b11 && modulator_rate_sel == 2'h3))
    else $error("fir rate wrong");
  a_zero_quiet: assert property (
    mode != 2'b01 |-> !left_zero_pin && !right_zero_pin)
    else $error("zero pin outside external mode");
  a_read_answer: assert property (
    cw_valid && cw_word[15] |=> rd_valid)
    else $error("read not answered");
  a_no_stray: assert property (
    !(cw_valid && cw_word[15]) |=> !rd_valid)
    else $error("answer without read");

  // Main scenarios reached
  c_extf: cover property (mode == 2'b01);
  c_stream: cover property (mode == 2'b11);
  c_half: cover property (fir_half_rate);
  c_read: cover property (rd_valid);
endmodule

bind dacbp_top dacbp_chk dacbp_chk_inst (.mclk, .rst, .cw_valid, .cw_word,
  .rd_valid, .mode, .filter_bypass, .left_zero_pin, .right_zero_pin,
  .input_format_sel, .modulator_rate_sel, .fir_response_sel, .osr_total,
  .fir_half_rate);

// ==== tb/dacbp_far.sv ====
`timescale 1ns/1ps
// Far end: external filter or one-bit stream source
module dacbp_far (
  // Link clock and reset
  output logic bclk,
  output logic brst,
  // Link pins
  output logic wrc,
  output logic lsi,
  output logic rsi,
  output logic frc,
  output logic sck
);
  // Frame and link clocks rest low outside frames
  initial begin
    {bclk, brst, wrc, lsi, rsi, frc, sck} = 7'h00;
  end
  // One link clock period
  task automatic tick();
    #62.5 bclk = 1'b1;
    #62.5 bclk = 1'b0;
  endtask
  // Link reset under three edges
  task automatic lreset();
    brst = 1'b1;
    repeat (3) tick();
    brst = 1'b0;
  endtask
  // Right-justified pair MSB first, then word edge
  task automatic send(input logic [23:0] l, input logic [23:0] r,
                      input int nb);
    for (int i = nb - 1; i >= 0; i--) begin
      wrc = 1'b0;
      lsi = l[i];
      rsi = r[i];
      tick();
    end
    lsi = ~lsi; // Released lines show inverse
    rsi = ~rsi;
    wrc = 1'b1;
    tick();
  endtask
  // One stream bit on left and right data pins, clocked on system pin
  task automatic bit1(input logic l, input logic r);
    lsi = l;
    rsi = r;
    #40 sck = 1'b1;
    #40 sck = 1'b0;
  endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
// Bench for the bypass input modes
module tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        cw_valid = 1'b0;
  logic [15:0] cw_word = 16'h0000;
  logic        bclk, brst, wrc, lsi, rsi, frc, sck;
  logic        rd_valid, pcm_strobe, fir_strobe, fb, lzp, rzp, hr;
  logic [7:0]  rd_data;
  logic [1:0]  mode, os, fsel, fir_data;
  logic [2:0]  fmt;
  logic [4:0]  osr;
  logic [3:0]  ctl;
  logic [23:0] pl, pr;
  int          fail_count = 0;
  int          num_checks = 0;
  int          osx[4] = '{8, 8, 16, 4};
  logic [47:0] q_pcm[$];
  logic [7:0]  q_rd[$];
  logic [1:0]  q_fir[$];

  always #4 mclk = ~mclk;

  dacbp_far dacbp_far_inst (.bclk(bclk), .brst(brst), .wrc(wrc),
    .lsi(lsi), .rsi(rsi), .frc(frc), .sck(sck));

  dacbp_top dacbp_top_inst (.mclk(mclk), .rst(rst),
    .serial_bit_clock(bclk), .link_rst(brst), .word_rate_clock(wrc),
    .left_serial_in(lsi), .right_serial_in(rsi), .frame_clock_in(frc),
    .system_clock_in(sck), .cw_valid(cw_valid), .cw_word(cw_word),
    .rd_valid(rd_valid), .rd_data(rd_data), .mode(mode),
    .filter_bypass(fb), .left_zero_pin(lzp), .right_zero_pin(rzp),
    .input_format_sel(fmt), .modulator_rate_sel(os),
    .fir_response_sel(fsel), .osr_total(osr), .fir_half_rate(hr),
    .output_enable_ctl(ctl[3]), .clock_divide_ctl(ctl[2]),
    .clock_enable_ctl(ctl[1]), .system_reset_bit(ctl[0]),
    .fir_data(fir_data), .fir_strobe(fir_strobe),
    .pcm_left(pl), .pcm_right(pr), .pcm_strobe(pcm_strobe));

  // Compare and count
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One control word held for one edge
  task automatic cw(input logic rd, input logic [6:0] ix,
                    input logic [7:0] d);
    @(posedge mclk);
    #1 cw_valid = 1'b1;
    cw_word = {rd, ix, d};
    @(posedge mclk);
    #1 cw_valid = 1'b0;
  endtask
  task automatic rde(input logic [6:0] ix, input logic [7:0] e);
    q_rd.push_back(e);
    cw(1'b1, ix, 8'h00);
  endtask
  function automatic logic [23:0] sx(input logic [23:0] v, input int nb);
    for (int i = 0; i < 24; i++) sx[i] = (i < nb) ? v[i] : v[nb - 1];
  endfunction

  // Takes the oldest note whenever a result appears
  always @(posedge mclk) begin
    #1;
    if (rd_valid === 1'b1)
      chk(48'(rd_data), q_rd.size() ? 48'(q_rd.pop_front()) : 'x);
    if (pcm_strobe === 1'b1)
      chk({pl, pr}, q_pcm.size() ? q_pcm.pop_front() : 'x);
    if (fir_strobe === 1'b1)
      chk(48'(fir_data), q_fir.size() ? 48'(q_fir.pop_front()) : 'x);
  end

  // Hang guard
  initial begin
    #500us;
    fail_count++;
    summarize();
  end

  initial begin
    logic [23:0] l, r;
    logic [1:0]  b;
    int          nb;
    void'($urandom(40507));
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    dacbp_far_inst.lreset();
    // Reset values, then masks and the read-only status
    for (int i = 16; i < 22; i++) rde(7'(i), 8'h00);
    rde(7'h20, 8'h00);
    cw(1'b0, 7'h15, 8'hff);
    cw(1'b0, 7'h12, 8'hff);
    cw(1'b0, 7'h13, 8'hff);
    cw(1'b0, 7'h14, 8'hd3);
    rde(7'h12, 8'h7e);
    rde(7'h13, 8'h1d);
    rde(7'h14, 8'h53);
    rde(7'h15, 8'h00);
    chk(48'({mode, fsel, fmt, hr, ctl}), 48'hf1f);
    // Mode reset clears everything
    cw(1'b0, 7'h14, 8'h20);
    repeat (2) @(posedge mclk);
    rde(7'h12, 8'h00);
    chk(48'({mode, fb, ctl}), 48'h0);
    // Stream mode through all four responses
    cw(1'b0, 7'h14, 8'h10);
    for (int f = 0; f < 4; f++) begin
      cw(1'b0, 7'h12, {4'h0, 2'(f), 2'b10});
      chk(48'({mode, fsel, hr}), 48'({2'b11, 2'(f), 1'b0}));
      repeat (4) begin
        b = 2'($urandom());
        q_fir.push_back({b[1], b[0]});
        dacbp_far_inst.bit1(b[0], b[1]);
      end
    end
    // External filter mode: every rate code
    cw(1'b0, 7'h12, 8'h00);
    for (int o = 0; o < 4; o++) begin
      cw(1'b0, 7'h14, {6'h04, 2'(o)});
      chk(48'({mode, os, osr}), 48'({2'b01, 2'(o), 5'(osx[o])}));
    end
    cw(1'b0, 7'h10, 8'hff);
    cw(1'b0, 7'h11, 8'hff);
    chk(48'({mode, fmt}), 48'h08);
    // Each word length, random data
    for (int f = 0; f < 3; f++) begin
      cw(1'b0, 7'h12, {1'b0, 3'(f), 4'h0});
      chk(48'(fmt), 48'(f));
      nb = 16 + 4 * f;
      repeat (2) begin
        l = 24'($urandom());
        r = 24'($urandom());
        q_pcm.push_back({sx(l, nb), sx(r, nb)});
        dacbp_far_inst.send(l, r, nb);
      end
    end
    // Short zero run must not raise the flags
    repeat (4) begin
      q_pcm.push_back(48'h0);
      dacbp_far_inst.send(24'h0, 24'h0, 24);
    end
    rde(7'h15, 8'h00);
    chk(48'({lzp, rzp}), 48'h0);
    for (int i = 0; i < 500 && q_pcm.size() + q_rd.size() + q_fir.size(); i++)
      @(posedge mclk);
    if (q_pcm.size() + q_rd.size() + q_fir.size() > 0) fail_count++;
    summarize();
  end
endmodule

// ==== verilog/dacbp_link.sv ====
`timescale 1ns/1ps
// Link-side receiver on the bit clock; gathers right-justified words
module dacbp_link (
  // Link clock and reset
  input  wire logic                 bclk,
  input  wire logic                 brst,
  // Pins
  input  wire logic                 word_rate_clock,
  input  wire logic                 left_serial_in,
  input  wire logic                 right_serial_in,
  // Word length from control domain (quasi-static)
  input  wire logic [2:0]           input_format_sel,
  // Captured pair and toggle event
  output dacbp_pkg::dacbp_pair_t    pair,
  output logic                      pair_tgl
);
  logic [23:0]           shl_reg, shl_next, shr_reg, shr_next;
  logic                  wck_reg, wck_next, tgl_reg, tgl_next;
  dacbp_pkg::dacbp_pair_t pr_reg, pr_next;

  // Right-justified: last N bits before word clock edge are the sample
  always_comb begin
    shl_next = {shl_reg[22:0], left_serial_in};
    shr_next = {shr_reg[22:0], right_serial_in};
    wck_next = word_rate_clock;
    tgl_next = tgl_reg;
    pr_next  = pr_reg;
    if (wck_next && !wck_reg) begin
      tgl_next = ~tgl_reg;
      case (input_format_sel)
        dacbp_pkg::FMT_20: begin
          pr_next.left  = {{4{shl_reg[19]}}, shl_reg[19:0]};
          pr_next.right = {{4{shr_reg[19]}}, shr_reg[19:0]};
        end
        dacbp_pkg::FMT_24: begin
          pr_next.left  = shl_reg;
          pr_next.right = shr_reg;
        end
        default: begin
          pr_next.left  = {{8{shl_reg[15]}}, shl_reg[15:0]};
          pr_next.right = {{8{shr_reg[15]}}, shr_reg[15:0]};
        end
      endcase
    end
  end

  // Registers on link clock
  always_ff @(posedge bclk) begin
    if (brst) begin
      shl_reg <= 24'h000000;
      shr_reg <= 24'h000000;
      wck_reg <= 1'b0;
      tgl_reg <= 1'b0;
      pr_reg  <= '0;
    end else begin
      shl_reg <= shl_next;
      shr_reg <= shr_next;
      wck_reg <= wck_next;
      tgl_reg <= tgl_next;
      pr_reg  <= pr_next;
    end
  end

  assign pair     = pr_reg;
  assign pair_tgl = tgl_reg;
endmodule

// ==== verilog/dacbp_top.sv ====
`timescale 1ns/1ps
// Bypass input modes of the converter front end
module dacbp_top (
  // Control clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Link clock and its reset
  input  wire logic        serial_bit_clock,
  input  wire logic        link_rst,
  // Link pins
  input  wire logic        word_rate_clock,
  input  wire logic        left_serial_in,
  input  wire logic        right_serial_in,
  input  wire logic        frame_clock_in,
  input  wire logic        system_clock_in,
  // Control word port
  input  wire logic        cw_valid,
  input  wire logic [15:0] cw_word,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  // Mode, status and data outputs
  output logic [1:0]       mode,
  output logic             filter_bypass,
  output logic             left_zero_pin,
  output logic             right_zero_pin,
  output logic [2:0]       input_format_sel,
  output logic [1:0]       modulator_rate_sel,
  output logic [1:0]       fir_response_sel,
  output logic [4:0]       osr_total,
  output logic             fir_half_rate,
  output logic             output_enable_ctl,
  output logic             clock_divide_ctl,
  output logic             clock_enable_ctl,
  output logic             system_reset_bit,
  output logic [1:0]       fir_data,
  output logic             fir_strobe,
  output logic [23:0]      pcm_left,
  output logic [23:0]      pcm_right,
  output logic             pcm_strobe
);
  // Register file
  logic [7:0] ra_reg, ra_next, rb_reg, rb_next;
  logic [7:0] r18_reg, r18_next, r19_reg, r19_next;
  logic [7:0] r20_reg, r20_next;
  logic       rdv_reg, rdv_next;
  logic [7:0] rdd_reg, rdd_next;
  dacbp_pkg::dacbp_cw_t cw;
  logic       stream_mode_enable;
  logic       zero_mute_enable;
  logic       mono_channel_select;
  logic       mode_register_reset;
  logic [1:0] zflag;
  // Zero-mute and channel select belong to the output stage outside this
  // block; they are decoded here so that stream mode can gate them

  assign cw = dacbp_pkg::dacbp_cw_t'(cw_word);

  // Read mux helper
  function automatic logic [7:0] rd_mux(input logic [6:0] idx,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
      input logic [7:0] d, input logic [7:0] e, input logic [1:0] z);
    case (idx)
      dacbp_pkg::REG_UNUSED_A: rd_mux = a;
      dacbp_pkg::REG_UNUSED_B: rd_mux = b;
      dacbp_pkg::REG_FMT_STRM: rd_mux = c;
      dacbp_pkg::REG_OUT_CLK:  rd_mux = d;
      dacbp_pkg::REG_RST_BYP:  rd_mux = e;
      dacbp_pkg::REG_ZERO:     rd_mux = {6'h00, z};
      default:                 rd_mux = 8'h00;
    endcase
  endfunction

  // Register writes and reads
  always_comb begin
    ra_next  = ra_reg;
    rb_next  = rb_reg;
    r18_next = r18_reg;
    r19_next = r19_reg;
    r20_next = r20_reg;
    rdv_next = 1'b0;
    rdd_next = rdd_reg;
    if (cw_valid && cw.rd) begin
      rdv_next = 1'b1;
      rdd_next = rd_mux(cw.index, ra_reg, rb_reg, r18_reg, r19_reg,
                        r20_reg, zflag);
    end else if (cw_valid) begin
      case (cw.index)
        dacbp_pkg::REG_UNUSED_A: ra_next = cw.data;
        dacbp_pkg::REG_UNUSED_B: rb_next = cw.data;
        dacbp_pkg::REG_FMT_STRM: r18_next = cw.data & dacbp_pkg::MASK_18;
        dacbp_pkg::REG_OUT_CLK:  r19_next = cw.data & dacbp_pkg::MASK_19;
        dacbp_pkg::REG_RST_BYP:  r20_next = cw.data & dacbp_pkg::MASK_20;
        default: ;
      endcase
    end
    // Mode-register reset returns every register to default
    if (r20_reg[dacbp_pkg::MODE_REGISTER_RESET_BIT]) begin
      ra_next  = dacbp_pkg::RST_VAL;
      rb_next  = dacbp_pkg::RST_VAL;
      r18_next = dacbp_pkg::RST_VAL;
      r19_next = dacbp_pkg::RST_VAL;
      r20_next = dacbp_pkg::RST_VAL;
    end
  end

  // Register storage
  always_ff @(posedge mclk) begin
    if (rst) begin
      ra_reg  <= dacbp_pkg::RST_VAL;
      rb_reg  <= dacbp_pkg::RST_VAL;
      r18_reg <= dacbp_pkg::RST_VAL;
      r19_reg <= dacbp_pkg::RST_VAL;
      r20_reg <= dacbp_pkg::RST_VAL;
      rdv_reg <= 1'b0;
      rdd_reg <= 8'h00;
    end else begin
      ra_reg  <= ra_next;
      rb_reg  <= rb_next;
      r18_reg <= r18_next;
      r19_reg <= r19_next;
      r20_reg <= r20_next;
      rdv_reg <= rdv_next;
      rdd_reg <= rdd_next;
    end
  end

  assign rd_valid = rdv_reg;
  assign rd_data  = rdd_reg;

  // Field decode
  assign filter_bypass       = r20_reg[dacbp_pkg::BYP_BIT];
  assign stream_mode_enable  = r18_reg[dacbp_pkg::STRM_BIT];
  assign mode_register_reset = r20_reg[dacbp_pkg::MODE_REGISTER_RESET_BIT];
  assign system_reset_bit    = r20_reg[dacbp_pkg::SYSTEM_RESET_BIT_BIT];
  assign modulator_rate_sel  = r20_reg[dacbp_pkg::OS_LSB +: 2];
  assign output_enable_ctl   = r19_reg[dacbp_pkg::OPE_BIT];
  assign clock_divide_ctl    = r19_reg[dacbp_pkg::CLOCK_DIVIDE_CTL_BIT];
  assign clock_enable_ctl    = r19_reg[dacbp_pkg::CLOCK_ENABLE_CTL_BIT];

  // Mode selection from bypass and stream enable
  always_comb begin
    if (!filter_bypass)
      mode = dacbp_pkg::DACBP_NORMAL;
    else if (stream_mode_enable)
      mode = dacbp_pkg::DACBP_STREAM;
    else
      mode = dacbp_pkg::DACBP_EXTF;
  end

  // Mode-dependent fields; stream mode gates the PCM-only controls
  always_comb begin
    input_format_sel    = 3'h0;
    zero_mute_enable    = 1'b0;
    mono_channel_select = 1'b0;
    fir_response_sel    = 2'h0;
    if (mode == dacbp_pkg::DACBP_STREAM) begin
      fir_response_sel = r18_reg[dacbp_pkg::FIR_LSB +: 2];
    end else begin
      input_format_sel    = r18_reg[dacbp_pkg::FMT_LSB +: 3];
      zero_mute_enable    = r19_reg[dacbp_pkg::ZERO_MUTE_ENABLE_BIT];
      mono_channel_select = r20_reg[dacbp_pkg::MONO_CHANNEL_SELECT_BIT];
    end
  end

  // Modulator rate multiplier for the selected code
  function automatic logic [4:0] mod_mult(input logic [1:0] os);
    case (os)
      dacbp_pkg::OS_X16: mod_mult = 5'h10;
      dacbp_pkg::OS_X4:  mod_mult = 5'h04;
      default:           mod_mult = 5'h08; // 01 reserved
    endcase
  endfunction

  // Modulator multiple of word clock; total is times the external 4x/8x
  always_comb begin
    osr_total     = 5'h00;
    fir_half_rate = 1'b0;
    if (mode == dacbp_pkg::DACBP_EXTF)
      osr_total = mod_mult(modulator_rate_sel);
    if (mode == dacbp_pkg::DACBP_STREAM)
      fir_half_rate = (modulator_rate_sel == 2'h3);
  end

  // Link receiver; any phase to mclk, so words cross by toggle
  // The link holds each pair for a whole word, so the fields are stable
  // long before the synchronised toggle reaches this side
  dacbp_pkg::dacbp_pair_t lpair;
  logic                   ltgl;
  dacbp_link dacbp_link_inst (
    .bclk             (serial_bit_clock),
    .brst             (link_rst),
    .word_rate_clock  (word_rate_clock),
    .left_serial_in   (left_serial_in),
    .right_serial_in  (right_serial_in),
    .input_format_sel (input_format_sel),
    .pair             (lpair),
    .pair_tgl         (ltgl)
  );

  // Three-stage sync of the toggle; a change counts when stages 2 and 3 agree
  logic [2:0]  tsync_reg, tsync_next;
  logic        tlast_reg, tlast_next;
  logic        pst_reg, pst_next;
  logic [23:0] pl_reg, pl_next, pr_reg, pr_next;
  always_comb begin
    tsync_next = {tsync_reg[1:0], ltgl};
    tlast_next = tlast_reg;
    pst_next   = 1'b0;
    pl_next    = pl_reg;
    pr_next    = pr_reg;
    if (tsync_reg[2] == tsync_reg[1] && tsync_reg[2] != tlast_reg) begin
      tlast_next = tsync_reg[2];
      if (mode == dacbp_pkg::DACBP_EXTF) begin
        pst_next = 1'b1;
        pl_next  = lpair.left;
        pr_next  = lpair.right;
      end
    end
  end

  // Sample crossing registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      tsync_reg <= 3'h0;
      tlast_reg <= 1'b0;
      pst_reg   <= 1'b0;
      pl_reg    <= 24'h000000;
      pr_reg    <= 24'h000000;
    end else begin
      tsync_reg <= tsync_next;
      tlast_reg <= tlast_next;
      pst_reg   <= pst_next;
      pl_reg    <= pl_next;
      pr_reg    <= pr_next;
    end
  end

  // Captured samples go straight to the output stage
  // Each pair stands until the next word edge has crossed over
  assign pcm_left   = pl_reg;
  assign pcm_right  = pr_reg;
  assign pcm_strobe = pst_reg;

  // Next zero-run count: restart on a nonzero sample, hold at the limit
  function automatic logic [dacbp_pkg::ZCNT_W-1:0] zero_run(
      input logic [dacbp_pkg::ZCNT_W-1:0] cnt, input logic [23:0] smp);
    if (smp != 24'h000000)
      zero_run = '0;
    else if (cnt == dacbp_pkg::ZCNT_W'(dacbp_pkg::ZERO_SAMPLES))
      zero_run = cnt;
    else
      zero_run = cnt + 1'b1;
  endfunction

  // True once a channel has seen the full run of zero samples
  function automatic logic zero_run_done(
      input logic [dacbp_pkg::ZCNT_W-1:0] cnt);
    zero_run_done = (cnt == dacbp_pkg::ZCNT_W'(dacbp_pkg::ZERO_SAMPLES));
  endfunction

  // Zero run counters per channel, one count per captured sample
  logic [dacbp_pkg::ZCNT_W-1:0] zcl_reg, zcl_next, zcr_reg, zcr_next;
  always_comb begin
    zcl_next = zcl_reg;
    zcr_next = zcr_reg;
    if (mode != dacbp_pkg::DACBP_EXTF) begin
      zcl_next = '0;
      zcr_next = '0;
    end else if (pst_reg) begin
      zcl_next = zero_run(zcl_reg, pl_reg);
      zcr_next = zero_run(zcr_reg, pr_reg);
    end
  end

  // Zero counters
  always_ff @(posedge mclk) begin
    if (rst) begin
      zcl_reg <= '0;
      zcr_reg <= '0;
    end else begin
      zcl_reg <= zcl_next;
      zcr_reg <= zcr_next;
    end
  end

  // Flags speak only in external-filter mode; bit 1 right, bit 0 left
  always_comb begin
    zflag = 2'b00;
    if (mode == dacbp_pkg::DACBP_EXTF) begin
      zflag[0] = zero_run_done(zcl_reg);
      zflag[1] = zero_run_done(zcr_reg);
    end
  end
  assign left_zero_pin  = zflag[0];
  assign right_zero_pin = zflag[1];

  // Stream path: system clock pin is the bit clock, sampled by three stages
  logic [2:0] sck_reg, sck_next;
  logic [2:0] sdl_reg, sdl_next, sdr_reg, sdr_next;
  logic [1:0] fd_reg, fd_next;
  logic       fs_reg, fs_next;
  logic       sckl_reg, sckl_next;
  always_comb begin
    sck_next = {sck_reg[1:0], system_clock_in};
    sdl_next = {sdl_reg[1:0], left_serial_in};
    sdr_next = {sdr_reg[1:0], right_serial_in};
    fd_next  = fd_reg;
    fs_next  = 1'b0;
    sckl_next = sckl_reg;
    // A level counts once stages 2 and 3 agree; a new high is a rising
    // edge, and the data bit of the same age passes straight through
    if (sck_reg[2] == sck_reg[1]) begin
      sckl_next = sck_reg[2];
      if (mode == dacbp_pkg::DACBP_STREAM && sck_reg[2] && !sckl_reg) begin
        fd_next = {sdr_reg[2], sdl_reg[2]};
        fs_next = 1'b1;
      end
    end
  end

  // Stream registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      sck_reg <= 3'h0;
      sdl_reg <= 3'h0;
      sdr_reg <= 3'h0;
      fd_reg  <= 2'h0;
      fs_reg  <= 1'b0;
      sckl_reg <= 1'b0;
    end else begin
      sck_reg <= sck_next;
      sdl_reg <= sdl_next;
      sdr_reg <= sdr_next;
      fd_reg  <= fd_next;
      fs_reg  <= fs_next;
      sckl_reg <= sckl_next;
    end
  end

  assign fir_data   = fd_reg;
  assign fir_strobe = fs_reg;
endmodule
